// >>> design/sram_lane_array.sv
// Byte-lane storage array with one write port and one registered read.
// Assumes write enables and address already sampled on the same clock.
`timescale 1ns/1ps
module sram_lane_array
    import sram_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic [sram_pkg::LANES-1:0] lane_we_i,
    input wire logic [sram_pkg::MEM_ADDR_W-1:0] addr_i,
    input wire logic [sram_pkg::DATA_W-1:0] wdata_i,
    input wire logic rd_en_i,
    output logic [sram_pkg::DATA_W-1:0] rdata_o
);

    // =====================================================
    // Storage, one flip-flop bank per lane
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [LANE_W-1:0] mem_r [2**MEM_ADDR_W];
            logic [LANE_W-1:0] rd_r;
            // Lane write, untouched when its enable is off
            always_ff @(posedge ref_clk_i) begin
                if (lane_we_i[g]) begin
                    mem_r[addr_i] <= wdata_i[g*LANE_W +: LANE_W];
                end
            end
            // Registered read
            always_ff @(posedge ref_clk_i) begin
                if (rd_en_i) begin
                    rd_r <= mem_r[addr_i];
                end
            end
            // Lane slice of the read word, one driver per slice
            assign rdata_o[g*LANE_W +: LANE_W] = rd_r;
        end
    endgenerate

endmodule // sram_lane_array

// >>> design/sram_pkg.sv
// Constants shared by the synchronous memory core and its lane array.
// Assumes one 10 MHz clock and pin inputs that come from outside it.
package sram_pkg;

    // =====================================================
    // Widths
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int ADDR_W = 21;
    localparam int MEM_ADDR_W = 8;
    localparam int CTRL_W = 13;

    // =====================================================
    // Control pin vector bit positions
    localparam int CS1_POS = 0;
    localparam int CS2_POS = 1;
    localparam int CS3_POS = 2;
    localparam int PSTB_POS = 3;
    localparam int CSTB_POS = 4;
    localparam int GW_POS = 5;
    localparam int BWE_POS = 6;
    localparam int BW_LO = 7;
    localparam int BW_HI = 10;
    localparam int SLEEP_POS = 11;
    localparam int OE_POS = 12;

    // =====================================================
    // Reset values: every active-low control inactive
    localparam logic [CTRL_W-1:0] CTRL_IDLE = 13'h17fd;
    localparam logic [ADDR_W-1:0] ADDR_RST = 21'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;

    // =====================================================
    // Timing: core power to first access, in microseconds
    localparam int CLK_MHZ = 10;
    localparam int POWER_UP_US = 1000;
    localparam int POWER_UP_CYC = POWER_UP_US * CLK_MHZ;

    // Data bus driver state
    typedef enum logic [1:0] {
        BUS_FLOAT,
        BUS_DRIVE,
        BUS_LAST
    } bus_state_t;

endpackage

// >>> design/sync_sram_core.sv
// Bus-side logic of a pipelined synchronous static memory.
// Assumes a controller on the same board drives every pin; all pin
// inputs are brought in through two flip-flops before use.
`timescale 1ns/1ps
module sync_sram_core
    import sram_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic chip_sel1_n_i,
    input wire logic chip_sel2_i,
    input wire logic chip_sel3_n_i,
    input wire logic processor_strobe_n_i,
    input wire logic controller_strobe_n_i,
    input wire logic global_write_n_i,
    input wire logic byte_write_enable_n_i,
    input wire logic [sram_pkg::LANES-1:0] byte_lane_write_n_i,
    input wire logic output_enable_n_i,
    input wire logic sleep_request_i,
    input wire logic [sram_pkg::ADDR_W-1:0] addr_i,
    input wire logic [sram_pkg::DATA_W-1:0] dq_i,
    output logic [sram_pkg::DATA_W-1:0] dq_o,
    output logic dq_oe_o,
    output logic sleeping_o
);

    import sram_pkg::*;

    // =====================================================
    // Pin synchronisers
    logic [CTRL_W-1:0] ctrl_meta_r;
    logic [CTRL_W-1:0] ctrl_r;
    logic [ADDR_W-1:0] addr_meta_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] data_meta_r;
    logic [DATA_W-1:0] data_r;
    wire [CTRL_W-1:0] ctrl_pins;

    // Control pins packed in package order
    assign ctrl_pins = {output_enable_n_i, sleep_request_i,
        byte_lane_write_n_i, byte_write_enable_n_i, global_write_n_i,
        controller_strobe_n_i, processor_strobe_n_i, chip_sel3_n_i,
        chip_sel2_i, chip_sel1_n_i};

    // Two-stage capture, idle levels under reset
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ctrl_meta_r <= CTRL_IDLE;
            ctrl_r <= CTRL_IDLE;
        end else begin
            ctrl_meta_r <= ctrl_pins;
            ctrl_r <= ctrl_meta_r;
        end
    end

    // Address and data capture
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            addr_meta_r <= ADDR_RST;
            addr_r <= ADDR_RST;
            data_meta_r <= DATA_RST;
            data_r <= DATA_RST;
        end else begin
            addr_meta_r <= addr_i;
            addr_r <= addr_meta_r;
            data_meta_r <= dq_i;
            data_r <= data_meta_r;
        end
    end

    // =====================================================
    // Decode of the captured pins
    wire selected;
    wire strobe;
    wire gw_n;
    wire bwe_n;
    wire [LANES-1:0] bw_n;
    wire [LANES-1:0] lane_we;
    wire any_write;
    wire start;
    wire desel_op;
    wire rd_start;
    wire wr_start;
    wire sleep_lvl;
    wire oe_n;
    wire [MEM_ADDR_W-1:0] mem_addr;
    wire [DATA_W-1:0] rdata;
    logic sleeping_r;

    // Three selects must all agree
    assign selected = ~ctrl_r[CS1_POS] & ctrl_r[CS2_POS]
        & ~ctrl_r[CS3_POS];
    assign strobe = ~ctrl_r[PSTB_POS] | ~ctrl_r[CSTB_POS];
    assign gw_n = ctrl_r[GW_POS];
    assign bwe_n = ctrl_r[BWE_POS];
    assign bw_n = ctrl_r[BW_HI:BW_LO];
    assign sleep_lvl = ctrl_r[SLEEP_POS];
    assign oe_n = ctrl_r[OE_POS];

    // Accesses ignored while asleep; entry assumes deselected bus
    assign start = strobe & selected & ~sleep_lvl & ~sleeping_r;
    assign desel_op = strobe & ~selected;

    // Per-lane write enables
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_we
            // Global write covers all lanes, else per-lane enable
            assign lane_we[g] = start & (~gw_n | (~bwe_n & ~bw_n[g]));
        end
    endgenerate

    assign any_write = |lane_we;
    assign wr_start = any_write;
    assign rd_start = start & ~any_write;
    assign mem_addr = addr_r[MEM_ADDR_W-1:0];

    // =====================================================
    // Storage
    sram_lane_array u_array (
        .ref_clk_i(ref_clk_i),
        .lane_we_i(lane_we),
        .addr_i(mem_addr),
        .wdata_i(data_r),
        .rd_en_i(rd_start),
        .rdata_o(rdata)
    );

    // =====================================================
    // Sleep tracking

    // Sleep follows the captured request level
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            sleeping_r <= 1'b0;
        end else begin
            sleeping_r <= sleep_lvl;
        end
    end

    assign sleeping_o = sleeping_r;

    // =====================================================
    // Read pipeline and data bus driver
    logic rd_pend_r;
    logic [DATA_W-1:0] dq_r;
    logic dq_oe_r;
    bus_state_t bus_r;
    bus_state_t bus_nxt;

    // Read data leaves the array one cycle after the start
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rd_pend_r <= 1'b0;
        end else begin
            rd_pend_r <= rd_start;
        end
    end

    // Next driver state
    always_comb begin
        bus_nxt = bus_r;
        unique case (bus_r)
            BUS_FLOAT: begin
                // Stays off after writes until a read arrives; a read
                // followed by a write shows its data for one cycle only
                if (rd_pend_r && wr_start) begin
                    bus_nxt = BUS_LAST;
                end else if (rd_pend_r) begin
                    bus_nxt = BUS_DRIVE;
                end
            end
            BUS_DRIVE: begin
                if (wr_start && rd_pend_r) begin
                    bus_nxt = BUS_LAST;
                end else if (wr_start) begin
                    bus_nxt = BUS_FLOAT;
                end else if (desel_op && !rd_pend_r) begin
                    bus_nxt = BUS_LAST;
                end
            end
            BUS_LAST: begin
                // One extra cycle on deselect, or for a read before a write
                if (rd_pend_r) begin
                    bus_nxt = BUS_DRIVE;
                end else begin
                    bus_nxt = BUS_FLOAT;
                end
            end
        endcase
        // Sleep forces the bus off, and it stays off on exit
        if (sleep_lvl || sleeping_r) begin
            bus_nxt = BUS_FLOAT;
        end
    end

    // Driver state register
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            bus_r <= BUS_FLOAT;
        end else begin
            bus_r <= bus_nxt;
        end
    end

    // Output data register, loaded when a read completes
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            dq_r <= DATA_RST;
        end else if (rd_pend_r) begin
            dq_r <= rdata;
        end
    end

    // Enable register gated by the output enable pin
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            dq_oe_r <= 1'b0;
        end else begin
            dq_oe_r <= (bus_nxt != BUS_FLOAT) & ~oe_n;
        end
    end

    assign dq_o = dq_r;
    assign dq_oe_o = dq_oe_r;

endmodule // sync_sram_core

// >>> sim/sram_bus_model.sv
// Shared data bus between the board controller and the memory core.
// Assumes the controller drives only in write cycles.
`timescale 1ns/1ps
module sram_bus_model
    import sram_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic host_oe_i,
    input wire logic [sram_pkg::DATA_W-1:0] host_d_i,
    input wire logic dev_oe_i,
    input wire logic [sram_pkg::DATA_W-1:0] dev_d_i,
    output logic [sram_pkg::DATA_W-1:0] bus_o
);
    logic [DATA_W-1:0] last_r;
    // =====================================================
    // Released bus shows the inverse of its last level
    always_ff @(posedge ref_clk_i) begin
        last_r <= bus_o;
    end
    assign bus_o = host_oe_i ? host_d_i : (dev_oe_i ? dev_d_i : ~last_r);
endmodule // sram_bus_model

// >>> sim/sync_sram_core_sva.sv
// Checker of the core's pin timing: select, writes, bus float, sleep.
// Assumes bind onto sync_sram_core; reads act on the bus four edges later, writes three.
`timescale 1ns/1ps
module sync_sram_core_sva
    import sram_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic chip_sel1_n_i,
    input wire logic chip_sel2_i,
    input wire logic chip_sel3_n_i,
    input wire logic processor_strobe_n_i,
    input wire logic controller_strobe_n_i,
    input wire logic global_write_n_i,
    input wire logic byte_write_enable_n_i,
    input wire logic [sram_pkg::LANES-1:0] byte_lane_write_n_i,
    input wire logic dq_oe_o,
    input wire logic sleeping_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // =====================================================
    // Pin decode
    wire sel = !chip_sel1_n_i && chip_sel2_i && !chip_sel3_n_i;
    wire stb = !processor_strobe_n_i || !controller_strobe_n_i;
    wire lane_wr = !byte_write_enable_n_i && !(&byte_lane_write_n_i);
    wire all_lanes = !byte_write_enable_n_i && byte_lane_write_n_i == 4'h0;
    wire rd = sel && stb && global_write_n_i && !lane_wr;
    sequence full_write_s;
        sel && stb && (!global_write_n_i || all_lanes) && !$past(rd);
    endsequence
    sequence lane_write_s;
        sel && stb && global_write_n_i && lane_wr && !$past(rd);
    endsequence
    sequence read_write_s;
        sel && stb && (!global_write_n_i || lane_wr) && $past(rd);
    endsequence
    // =====================================================
    // Properties
    AST_SEL_DECODE: assert property ($rose(dq_oe_o) |-> $past(sel, 4))
        else $error("bus driven without the select pattern");
    AST_FULL_WRITE_FLOAT: assert property (full_write_s |-> ##3 !dq_oe_o)
        else $error("bus still driven after full write");
    AST_LANE_WRITE_FLOAT: assert property (lane_write_s |-> ##3 !dq_oe_o)
        else $error("lane write taken as a read");
    AST_FLOAT_UNTIL_READ: assert property ($rose(dq_oe_o) |-> $past(rd, 4))
        else $error("bus driven without a new read");
    AST_WAKE_FLOAT: assert property ($fell(sleeping_o) |-> !dq_oe_o [*2])
        else $error("bus driven on leaving sleep");
    AST_READ_WRITE_FLOAT: assert property (read_write_s |-> ##4 !dq_oe_o)
        else $error("bus still driven after read then write");
endmodule // sync_sram_core_sva
bind sync_sram_core sync_sram_core_sva i_sva (.ref_clk_i, .sys_rst_i,
    .chip_sel1_n_i, .chip_sel2_i, .chip_sel3_n_i, .processor_strobe_n_i,
    .controller_strobe_n_i, .global_write_n_i, .byte_write_enable_n_i,
    .byte_lane_write_n_i, .dq_oe_o, .sleeping_o);

// >>> sim/sync_sram_select_write_sleep_tb_top.sv
// Self-checking bench for the memory core with a board bus model.
// Assumes a 10 MHz clock and one access at a time from the bench.
`timescale 1ns/1ps
module sync_sram_select_write_sleep_tb_top;
    import sram_pkg::*;
    typedef struct packed {
        logic [2:0] sel; logic gw; logic byte_write_enable_n; logic [3:0] bw;
        logic [7:0] a; logic [35:0] d; logic oe; logic [35:0] q;
    } row_t;
    row_t rows [8] = '{
        {3'h2, 1'h0, 1'h1, 4'hf, 8'h01, 36'h123456789, 1'h0, 36'h0},
        {3'h2, 1'h1, 1'h1, 4'hf, 8'h01, 36'h000000000, 1'h1, 36'h123456789},
        {3'h2, 1'h1, 1'h0, 4'h0, 8'h02, 36'habcdef012, 1'h0, 36'h0},
        {3'h2, 1'h1, 1'h1, 4'hf, 8'h02, 36'h000000000, 1'h1, 36'habcdef012},
        {3'h2, 1'h0, 1'h1, 4'hf, 8'h03, 36'h000000000, 1'h0, 36'h0},
        {3'h2, 1'h1, 1'h0, 4'ha, 8'h03, 36'hfffffffff, 1'h0, 36'h0},
        {3'h2, 1'h1, 1'h0, 4'hf, 8'h03, 36'hfffffffff, 1'h1, 36'h007fc01ff},
        {3'h2, 1'h1, 1'h1, 4'hf, 8'h03, 36'h000000000, 1'h1, 36'h007fc01ff}};
    row_t w;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic sel1_n = 1'b1, sel2 = 1'b0, sel3_n = 1'b1, pstb_n = 1'b1;
    logic cstb_n = 1'b1, gw_n = 1'b1, bwe_n = 1'b1, sleep = 1'b0;
    logic host_oe = 1'b0;
    logic [3:0] bw_n = 4'hf;
    logic [ADDR_W-1:0] addr = 21'h000000;
    logic [DATA_W-1:0] host_d = 36'h0, bus, dq_o;
    logic dq_oe_o, sleeping_o;
    int failures = 0, cmp_count = 0;
    // =====================================================
    // Clock, device and bus
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    sync_sram_core i_dut (.ref_clk_i(ref_clk), .sys_rst_i(rst),
        .chip_sel1_n_i(sel1_n), .chip_sel2_i(sel2), .chip_sel3_n_i(sel3_n),
        .processor_strobe_n_i(pstb_n), .controller_strobe_n_i(cstb_n),
        .global_write_n_i(gw_n), .byte_write_enable_n_i(bwe_n),
        .byte_lane_write_n_i(bw_n), .output_enable_n_i(1'b0),
        .sleep_request_i(sleep), .addr_i(addr), .dq_i(bus), .dq_o(dq_o),
        .dq_oe_o(dq_oe_o), .sleeping_o(sleeping_o));
    sram_bus_model i_bus (.ref_clk_i(ref_clk), .host_oe_i(host_oe),
        .host_d_i(host_d), .dev_oe_i(dq_oe_o), .dev_d_i(dq_o), .bus_o(bus));
    // =====================================================
    // Tasks
    task automatic drive(input row_t r, input logic proc);
        @(posedge ref_clk);
        {sel1_n, sel2, sel3_n, gw_n, bwe_n, bw_n} <= {r.sel, r.gw, r.byte_write_enable_n, r.bw};
        {pstb_n, cstb_n, host_oe} <= {!proc, proc, !(r.gw & (r.byte_write_enable_n | &r.bw))};
        addr <= {13'h0000, r.a};
        host_d <= r.d;
    endtask
    task automatic idle_wait();
        @(posedge ref_clk);
        {sel1_n, sel2, sel3_n, gw_n, bwe_n, bw_n, pstb_n, cstb_n} <= 11'h5ff;
        host_oe <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // =====================================================
    // Watchdog
    initial begin
        #1500000;
        failures++;
        report_and_stop();
    end
    // =====================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(dq_o, 36'h0);
        chk({34'h0, dq_oe_o, sleeping_o}, 36'h0);
        repeat (POWER_UP_CYC) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            drive(rows[i], i[0]);
            idle_wait();
            chk({35'h0, dq_oe_o}, {35'h0, rows[i].oe});
            if (rows[i].oe) chk(dq_o, rows[i].q);
        end
        w = rows[0];
        w.d = 36'h0;
        for (int s = 0; s < 8; s++) begin
            w.sel = s[2:0];
            if (s != 2) drive(w, s[0]);
            if (s != 2) idle_wait();
        end
        drive(rows[1], 1'b0);
        idle_wait();
        chk(dq_o, rows[1].q);
        w = rows[0];
        w.a = 8'h04;
        w.d = 36'h5a5a5a5a5;
        drive(w, 1'b1);
        w = rows[1];
        w.a = 8'h04;
        drive(w, 1'b0);
        idle_wait();
        chk(dq_o, 36'h5a5a5a5a5);
        @(posedge ref_clk);
        sleep <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        chk({34'h0, sleeping_o, dq_oe_o}, 36'h2);
        w = rows[0];
        w.d = 36'h0;
        drive(w, 1'b1);
        idle_wait();
        @(posedge ref_clk);
        sleep <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        chk({34'h0, sleeping_o, dq_oe_o}, 36'h0);
        w.a = 8'h05;
        drive(rows[3], 1'b1);
        drive(w, 1'b0);
        idle_wait();
        chk(dq_o, rows[3].q);
        chk({35'h0, dq_oe_o}, 36'h0);
        drive(rows[1], 1'b1);
        idle_wait();
        chk(dq_o, rows[1].q);
        report_and_stop();
    end
endmodule // sync_sram_select_write_sleep_tb_top
